// ===== rx_status_pkg.sv
// constants for the receiver status readout registers
// assumes an 8-bit register address space reached by the serial port logic
package rx_status_pkg;
    // register offsets
    localparam logic [7:0] OFS_CHANNEL_CONFIG_STATUS = 8'hAA;
    localparam logic [7:0] OFS_RECEPTION_PEAK_LEVEL = 8'hAB;
    localparam logic [7:0] OFS_PAYLOAD_PEAK_LEVEL = 8'hAC;
    localparam logic [7:0] OFS_PAYLOAD_LENGTH_LOW = 8'hAD;
    localparam logic [7:0] OFS_ADC_RESULT_HIGH = 8'hAE;
    localparam logic [7:0] OFS_ADC_RESULT_LOW = 8'hAF;

    // field positions in channel_config_status
    localparam int POS_LEN_HI_MSB = 7;
    localparam int POS_LEN_HI_LSB = 6;
    localparam int POS_ACTIVE_CFG = 4;
    localparam int POS_FIFO_CHANNEL = 2;
    localparam int POS_WAKEUP_FOUND = 0;
    // field position in adc_result_low
    localparam int POS_ADC_DONE = 2;

    // widths
    localparam int LEVEL_W = 8;
    localparam int LEN_W = 10;
    localparam int ADC_W = 10;
    localparam int BITPOS_W = 10;

    // values after reset
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [9:0] RST_LEN = 10'h000;
    localparam logic [9:0] RST_ADC = 10'h000;
    localparam logic [9:0] RST_BITCNT = 10'h000;

    // payload peak phase, gray coded along idle -> wait -> track
    typedef enum logic [1:0] {
        PHASE_IDLE = 2'b00,
        PHASE_WAIT_POS = 2'b01,
        PHASE_TRACK = 2'b11
    } payload_phase_t;
endpackage

// ===== peak_if.sv
// bundle between the status block and one signal-strength peak holder
// assumes both ends share clk, rst_n and the clock enable
interface peak_if #(parameter int LEVEL_W = 8);
    logic [LEVEL_W-1:0] level;
    logic track_en;
    logic clear;
    logic [LEVEL_W-1:0] peak;
    modport holder (input level, input track_en, input clear, output peak);
    modport user (output level, output track_en, output clear, input peak);
endinterface

// ===== peak_holder.sv
// signal-strength peak holder: keeps the highest level seen while tracking
// assumes level, track_en and clear come from logic on the same clock
module peak_holder #(
    parameter int LEVEL_W = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    peak_if.holder pk
);
    logic [LEVEL_W-1:0] peak_reg;
    logic [LEVEL_W-1:0] peak_next;

    // a clear that meets a live sample restarts from that sample, so a
    // level arriving in the clearing cycle is not lost
    always_comb begin
        peak_next = peak_reg;
        if (pk.clear) begin
            peak_next = pk.track_en ? pk.level : '0;
        end else if (pk.track_en && (pk.level > peak_reg)) begin
            peak_next = pk.level;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            peak_reg <= '0;
        end else if (ce) begin
            peak_reg <= peak_next;
        end
    end

    assign pk.peak = peak_reg;
endmodule

// ===== receiver_status_readout.sv
// read-only status registers of the receiver: channel and configuration,
// payload length, two peak holders and the adc result with its done flag
// assumes all inputs come from receiver logic on clk; reads arrive as a
// one-cycle strobe with an address from the serial port logic
//
// Functional notes
// - capture payload length at message start; bits 9:8 go to status
// - fifo initialisation clears all ten payload length bits
// - status bit 4 shows active configuration, 0 is A, 1 is B
// - status bit 2: 0 no valid fifo data, 1 data from channel 1
// - status bit 0: 1 wake-up found on channel 1, else 0
// - reception peak tracks while receiver enabled, loads only higher
// - reception peak clears at reset and on a read with receiver off; a read while enabled loads the live level
// - payload peak tracking starts after frame sync plus start position
// - payload peak loaded at every end of message, cleared by reset
// - adc bits 9:2 in high register, bits 1:0 in low register
// - low adc bits latched when high register read; read high first
// - reading the high register only strobes, never clears the result
// - low register bit 2 reads 1 once conversion end seen
module receiver_status_readout #(
    parameter int LEVEL_W = rx_status_pkg::LEVEL_W
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic rd_strobe,
    input wire logic [7:0] rd_addr,
    output logic [7:0] rd_data,
    output logic rd_valid,
    input wire logic [LEVEL_W-1:0] rssi_level,
    input wire logic rx_enable,
    input wire logic frame_sync_event,
    input wire logic bit_strobe,
    input wire logic [rx_status_pkg::BITPOS_W-1:0] peak_start_bit_position,
    input wire logic end_of_message_event,
    input wire logic message_start_detect,
    input wire logic [rx_status_pkg::LEN_W-1:0] payload_length,
    input wire logic fifo_init,
    input wire logic active_configuration,
    input wire logic fifo_channel_valid,
    input wire logic wakeup_channel_found,
    input wire logic adc_conversion_done,
    input wire logic [rx_status_pkg::ADC_W-1:0] adc_result_value
);
    logic [rx_status_pkg::LEN_W-1:0] len_reg;
    logic [rx_status_pkg::LEN_W-1:0] len_next;
    logic [7:0] status_reg;
    logic [7:0] status_next;
    logic [rx_status_pkg::ADC_W-1:0] adc_reg;
    logic [rx_status_pkg::ADC_W-1:0] adc_next;
    logic [1:0] adc_low_reg;
    logic [1:0] adc_low_next;
    logic adc_done_reg;
    logic adc_done_next;
    logic [LEVEL_W-1:0] pl_peak_reg;
    logic [LEVEL_W-1:0] pl_peak_next;
    rx_status_pkg::payload_phase_t phase_reg;
    rx_status_pkg::payload_phase_t phase_next;
    logic [rx_status_pkg::BITPOS_W-1:0] bitcnt_reg;
    logic [rx_status_pkg::BITPOS_W-1:0] bitcnt_next;
    logic [7:0] rd_data_reg;
    logic [7:0] rd_data_next;
    logic rd_valid_reg;
    logic rd_high;
    logic rd_low;
    logic rd_rx_peak;

    peak_if #(.LEVEL_W(LEVEL_W)) rx_pk();
    peak_if #(.LEVEL_W(LEVEL_W)) pl_pk();

    // address decode of the read strobe
    assign rd_high = rd_strobe &&
        (rd_addr == rx_status_pkg::OFS_ADC_RESULT_HIGH);
    assign rd_low = rd_strobe &&
        (rd_addr == rx_status_pkg::OFS_ADC_RESULT_LOW);
    assign rd_rx_peak = rd_strobe &&
        (rd_addr == rx_status_pkg::OFS_RECEPTION_PEAK_LEVEL);

    // reception peak: live while the receiver runs; its read clears it, or restarts it from the live level while running
    assign rx_pk.level = rssi_level;
    assign rx_pk.track_en = rx_enable;
    assign rx_pk.clear = rd_rx_peak;

    peak_holder #(.LEVEL_W(LEVEL_W)) u_rx_peak (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .pk(rx_pk.holder)
    );

    // payload peak: restarted at each frame sync, live only in track phase
    assign pl_pk.level = rssi_level;
    assign pl_pk.track_en =
        (phase_reg == rx_status_pkg::PHASE_TRACK);
    assign pl_pk.clear = frame_sync_event;

    peak_holder #(.LEVEL_W(LEVEL_W)) u_pl_peak (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .pk(pl_pk.holder)
    );

    // payload phase: count received bits after frame sync up to the start
    always_comb begin
        phase_next = phase_reg;
        bitcnt_next = bitcnt_reg;
        case (phase_reg)
            rx_status_pkg::PHASE_IDLE: begin
                if (frame_sync_event) begin
                    phase_next = rx_status_pkg::PHASE_WAIT_POS;
                    bitcnt_next = rx_status_pkg::RST_BITCNT;
                end
            end
            rx_status_pkg::PHASE_WAIT_POS: begin
                if (end_of_message_event) begin
                    phase_next = rx_status_pkg::PHASE_IDLE;
                end else if (bitcnt_reg >= peak_start_bit_position) begin
                    phase_next = rx_status_pkg::PHASE_TRACK;
                end else if (bit_strobe) begin
                    bitcnt_next = bitcnt_reg + 1'b1;
                end
            end
            rx_status_pkg::PHASE_TRACK: begin
                if (end_of_message_event) begin
                    phase_next = rx_status_pkg::PHASE_IDLE;
                end
            end
            default: begin
                phase_next = rx_status_pkg::PHASE_IDLE;
            end
        endcase
        // a new frame sync always restarts the position count
        if (frame_sync_event) begin
            phase_next = rx_status_pkg::PHASE_WAIT_POS;
            bitcnt_next = rx_status_pkg::RST_BITCNT;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            phase_reg <= rx_status_pkg::PHASE_IDLE;
            bitcnt_reg <= rx_status_pkg::RST_BITCNT;
        end else if (ce) begin
            phase_reg <= phase_next;
            bitcnt_reg <= bitcnt_next;
        end
    end

    // payload peak register, length and live status bits
    always_comb begin
        pl_peak_next = pl_peak_reg;
        if (end_of_message_event) begin
            pl_peak_next = pl_pk.peak;
        end
        len_next = len_reg;
        // capture beats init in the same cycle: the new message stands
        if (message_start_detect) begin
            len_next = payload_length;
        end else if (fifo_init) begin
            len_next = rx_status_pkg::RST_LEN;
        end
        status_next = rx_status_pkg::RST_BYTE;
        status_next[rx_status_pkg::POS_LEN_HI_MSB:
            rx_status_pkg::POS_LEN_HI_LSB] =
            len_next[rx_status_pkg::LEN_W-1:rx_status_pkg::LEN_W-2];
        status_next[rx_status_pkg::POS_ACTIVE_CFG] =
            active_configuration;
        status_next[rx_status_pkg::POS_FIFO_CHANNEL] =
            fifo_channel_valid;
        status_next[rx_status_pkg::POS_WAKEUP_FOUND] =
            wakeup_channel_found;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pl_peak_reg <= '0;
            len_reg <= rx_status_pkg::RST_LEN;
            status_reg <= rx_status_pkg::RST_BYTE;
        end else if (ce) begin
            pl_peak_reg <= pl_peak_next;
            len_reg <= len_next;
            status_reg <= status_next;
        end
    end

    // adc result, low-bit snapshot and done flag
    always_comb begin
        adc_next = adc_reg;
        if (adc_conversion_done) begin
            adc_next = adc_result_value;
        end
        adc_low_next = adc_low_reg;
        // snapshot keeps the pair consistent if a conversion ends between
        // the two byte reads
        if (rd_high) begin
            adc_low_next = adc_reg[1:0];
        end
        // done flag: a new conversion end wins over the clearing read
        adc_done_next = adc_done_reg;
        if (adc_conversion_done) begin
            adc_done_next = 1'b1;
        end else if (rd_low) begin
            adc_done_next = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            adc_reg <= rx_status_pkg::RST_ADC;
            adc_low_reg <= 2'h0;
            adc_done_reg <= 1'b0;
        end else if (ce) begin
            adc_reg <= adc_next;
            adc_low_reg <= adc_low_next;
            adc_done_reg <= adc_done_next;
        end
    end

    // read data mux; unmapped addresses read as zero
    always_comb begin
        rd_data_next = rd_data_reg;
        if (rd_strobe) begin
            case (rd_addr)
                rx_status_pkg::OFS_CHANNEL_CONFIG_STATUS: begin
                    rd_data_next = status_reg;
                end
                rx_status_pkg::OFS_RECEPTION_PEAK_LEVEL: begin
                    rd_data_next = rx_pk.peak;
                end
                rx_status_pkg::OFS_PAYLOAD_PEAK_LEVEL: begin
                    rd_data_next = pl_peak_reg;
                end
                rx_status_pkg::OFS_PAYLOAD_LENGTH_LOW: begin
                    rd_data_next = len_reg[7:0];
                end
                rx_status_pkg::OFS_ADC_RESULT_HIGH: begin
                    rd_data_next = adc_reg[9:2];
                end
                rx_status_pkg::OFS_ADC_RESULT_LOW: begin
                    rd_data_next =
                        {5'h00, adc_done_reg, adc_low_reg};
                end
                default: begin
                    rd_data_next = rx_status_pkg::RST_BYTE;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rd_data_reg <= rx_status_pkg::RST_BYTE;
            rd_valid_reg <= 1'b0;
        end else if (ce) begin
            rd_data_reg <= rd_data_next;
            rd_valid_reg <= rd_strobe;
        end
    end

    assign rd_data = rd_data_reg;
    assign rd_valid = rd_valid_reg;

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence seq_high_read;
        ce && rd_high;
    endsequence
    sequence seq_low_read;
        ce && rd_low;
    endsequence

    chk_len_capture: assert property (
        ce && message_start_detect |=> len_reg == $past(payload_length) &&
        status_reg[7:6] == $past(payload_length[9:8]))
        else $error("payload length not captured");
    chk_len_clear: assert property (
        ce && fifo_init && !message_start_detect |=> len_reg == 10'h000)
        else $error("payload length not cleared by fifo init");
    chk_cfg_bit: assert property (
        ce |=> status_reg[4] == $past(active_configuration))
        else $error("active configuration bit wrong");
    chk_fifo_chan_bit: assert property (
        ce |=> status_reg[2] == $past(fifo_channel_valid))
        else $error("fifo channel bit wrong");
    chk_wakeup_bit: assert property (
        ce |=> status_reg[0] == $past(wakeup_channel_found))
        else $error("wake-up channel bit wrong");
    chk_rx_peak_rise: assert property (
        ce && rx_enable && !rd_rx_peak && rssi_level > rx_pk.peak
        |=> rx_pk.peak == $past(rssi_level))
        else $error("reception peak missed a higher level");
    chk_rx_peak_idle: assert property (
        ce && !rx_enable && !rd_rx_peak |=> $stable(rx_pk.peak))
        else $error("reception peak moved while receiver off");
    chk_rx_read_clear: assert property (
        ce && rd_rx_peak && !rx_enable
        |=> rx_pk.peak == 8'h00 && rd_data == $past(rx_pk.peak))
        else $error("reception peak not cleared by read");
    chk_pl_track_gate: assert property (
        ce && frame_sync_event |=> !pl_pk.track_en)
        else $error("payload tracking started at frame sync");
    chk_pl_eom_load: assert property (
        ce && end_of_message_event |=> pl_peak_reg == $past(pl_pk.peak))
        else $error("payload peak not loaded at end of message");
    chk_pl_hold: assert property (
        ce && !end_of_message_event |=> $stable(pl_peak_reg))
        else $error("payload peak changed without end of message");
    chk_adc_high: assert property (
        seq_high_read |=> rd_data == $past(adc_reg[9:2]) && rd_valid)
        else $error("adc high byte wrong");
    chk_adc_low_latch: assert property (
        seq_high_read |=> adc_low_reg == $past(adc_reg[1:0]))
        else $error("adc low bits not latched at high read");
    chk_adc_low_out: assert property (
        seq_low_read |=> rd_data ==
        {5'h00, $past(adc_done_reg), $past(adc_low_reg)})
        else $error("adc low byte wrong");
    chk_adc_no_clear: assert property (
        seq_high_read and (!adc_conversion_done) |=> $stable(adc_reg))
        else $error("high byte read disturbed the adc result");
    chk_adc_done: assert property (
        ce && adc_conversion_done |=> adc_done_reg ##0
        (adc_done_reg throughout (!(ce && rd_low) [*1])))
        else $error("adc done flag not set");
endmodule

// ===== rx_host_model.sv
// host model that reads the status registers over the read port
// assumes the answer arrives one enabled clock after the strobe is taken
module rx_host_model (
    input wire logic clk,
    output logic rd_strobe,
    output logic [7:0] rd_addr,
    input wire logic [7:0] rd_data,
    input wire logic rd_valid
);
    timeunit 1ns;
    timeprecision 1ps;

    // idle port before the first read
    initial begin
        rd_strobe = 1'b0;
        rd_addr = 8'h00;
    end

    // one read: strobe taken at one edge, answer picked up just after it;
    // returns on a rising edge so callers drive their inputs there
    task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
        int n;
        n = 0;
        @(posedge clk);
        rd_strobe <= 1'b1;
        rd_addr <= addr;
        @(posedge clk);
        rd_strobe <= 1'b0;
        rd_addr <= ~addr; // a released address never shows the old value
        #1;
        while (rd_valid !== 1'b1 && n < 8) begin
            @(posedge clk);
            #1;
            n++;
        end
        data = (rd_valid === 1'b1) ? rd_data : 8'hXX;
        @(posedge clk);
    endtask
endmodule

// ===== receiver_status_readout_tb.sv
// self-checking bench for the receiver status readout registers
// assumes the host model in rx_host_model.sv drives the read port
module receiver_status_readout_tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk, rst_n, rd_strobe, rd_valid, rx_enable, frame_sync_event;
    logic bit_strobe, end_of_message_event, message_start_detect, fifo_init;
    logic active_configuration, fifo_channel_valid, wakeup_channel_found;
    logic adc_conversion_done, ce;
    logic [7:0] rd_addr, rd_data, rssi_level;
    logic [9:0] peak_start_bit_position, payload_length, adc_result_value;
    int errors = 0;
    int n_tests = 0;

    // clock enable driven by the bench; t_freeze drops it for one edge
    receiver_status_readout uut (.clk(clk), .rst_n(rst_n), .ce(ce),
        .rd_strobe(rd_strobe), .rd_addr(rd_addr), .rd_data(rd_data),
        .rd_valid(rd_valid), .rssi_level(rssi_level), .rx_enable(rx_enable),
        .frame_sync_event(frame_sync_event), .bit_strobe(bit_strobe),
        .peak_start_bit_position(peak_start_bit_position),
        .end_of_message_event(end_of_message_event),
        .message_start_detect(message_start_detect),
        .payload_length(payload_length), .fifo_init(fifo_init),
        .active_configuration(active_configuration),
        .fifo_channel_valid(fifo_channel_valid),
        .wakeup_channel_found(wakeup_channel_found),
        .adc_conversion_done(adc_conversion_done),
        .adc_result_value(adc_result_value));

    rx_host_model host (.clk(clk), .rd_strobe(rd_strobe), .rd_addr(rd_addr),
        .rd_data(rd_data), .rd_valid(rd_valid));

    // 100 MHz clock
    always #5 clk = ~clk;

    task automatic check(input string what, input logic [7:0] seen,
                         input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic rd_chk(input logic [7:0] a, input string what,
                          input logic [7:0] exp);
        logic [7:0] d;
        host.read_reg(a, d);
        check(what, d, exp);
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // every register and one unmapped address read zero after reset
    task automatic t_reset();
        for (int a = 8'hAA; a <= 8'hB0; a++) begin
            rd_chk(8'(a), "reset value", 8'h00);
        end
    endtask

    // level bits, length capture at message start, clear by fifo init
    task automatic t_status();
        @(posedge clk);
        active_configuration <= 1'b1;
        fifo_channel_valid <= 1'b1;
        wakeup_channel_found <= 1'b1;
        message_start_detect <= 1'b1;
        payload_length <= 10'h3FF;
        @(posedge clk);
        message_start_detect <= 1'b0;
        payload_length <= 10'h000; // length only valid with the detect
        rd_chk(8'hAA, "status set", 8'hD5);
        rd_chk(8'hAD, "length low max", 8'hFF);
        fifo_init <= 1'b1;
        @(posedge clk);
        fifo_init <= 1'b0;
        rd_chk(8'hAA, "status after init", 8'h15);
        rd_chk(8'hAD, "length low init", 8'h00);
        active_configuration <= 1'b0;
        fifo_channel_valid <= 1'b0;
        wakeup_channel_found <= 1'b0;
        message_start_detect <= 1'b1;
        payload_length <= 10'h155;
        @(posedge clk);
        message_start_detect <= 1'b0;
        rd_chk(8'hAA, "status hi", 8'h40);
        rd_chk(8'hAD, "length low split", 8'h55);
    endtask

    // reception peak: only higher levels, only while enabled, read clears
    task automatic t_rx_peak();
        rd_chk(8'hAB, "peak idle", 8'h00);
        rx_enable <= 1'b1;
        rssi_level <= 8'h40;
        @(posedge clk);
        rssi_level <= 8'h20;
        @(posedge clk);
        rx_enable <= 1'b0;
        rssi_level <= 8'h70;
        repeat (2) @(posedge clk);
        rd_chk(8'hAB, "peak held", 8'h40);
        rd_chk(8'hAB, "peak after read", 8'h00);
    endtask

    // payload peak ignores levels before sync plus start position
    task automatic t_pl_peak();
        @(posedge clk);
        rx_enable <= 1'b1;
        peak_start_bit_position <= 10'h002;
        rssi_level <= 8'h90;
        frame_sync_event <= 1'b1;
        @(posedge clk);
        frame_sync_event <= 1'b0;
        for (int i = 0; i < 2; i++) begin
            @(posedge clk) bit_strobe <= 1'b1;
            @(posedge clk) bit_strobe <= 1'b0;
        end
        rssi_level <= 8'h30;
        @(posedge clk) rssi_level <= 8'h50;
        repeat (2) @(posedge clk);
        rssi_level <= 8'h10;
        end_of_message_event <= 1'b1;
        @(posedge clk);
        end_of_message_event <= 1'b0;
        rx_enable <= 1'b0;
        rd_chk(8'hAC, "payload peak", 8'h50);
        rd_chk(8'hAC, "payload peak kept", 8'h50);
    endtask

    // adc halves, snapshot on high read, done flag
    task automatic t_adc();
        @(posedge clk);
        adc_conversion_done <= 1'b1;
        adc_result_value <= 10'h2D6;
        @(posedge clk);
        adc_conversion_done <= 1'b0;
        adc_result_value <= 10'h001;
        rd_chk(8'hAE, "adc high", 8'hB5);
        rd_chk(8'hAF, "adc low done", 8'h06);
        rd_chk(8'hAF, "adc low cleared", 8'h02);
        rd_chk(8'hAE, "adc high kept", 8'hB5);
        adc_conversion_done <= 1'b1;
        adc_result_value <= 10'h0FD;
        @(posedge clk);
        adc_conversion_done <= 1'b0;
        rd_chk(8'hAF, "adc low stale", 8'h06);
        rd_chk(8'hAE, "adc high new", 8'h3F);
        rd_chk(8'hAF, "adc low new", 8'h01);
    endtask

    // clock enable low: a message start in that cycle must not be taken
    task automatic t_freeze();
        ce <= 1'b0;
        message_start_detect <= 1'b1;
        payload_length <= 10'h2AA;
        @(posedge clk);
        ce <= 1'b1;
        message_start_detect <= 1'b0;
        payload_length <= 10'h000;
        rd_chk(8'hAD, "length frozen", 8'h55);
    endtask

    // watchdog: the scenarios need well under a thousand cycles
    initial begin
        #100000;
        errors++;
        close_out();
    end

    // main sequence
    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        ce = 1'b1;
        {rx_enable, frame_sync_event, bit_strobe, end_of_message_event} = '0;
        {message_start_detect, fifo_init, active_configuration} = '0;
        {fifo_channel_valid, wakeup_channel_found, adc_conversion_done} = '0;
        rssi_level = 8'h00;
        peak_start_bit_position = 10'h000;
        payload_length = 10'h000;
        adc_result_value = 10'h000;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_status();
        t_rx_peak();
        t_pl_peak();
        t_adc();
        t_freeze();
        close_out();
    end
endmodule
